// file: pkg/wmx_pkg.sv
// Package: operation codes, widths and timing of the wide-multiply datapath slice
`default_nettype none
package wmx_pkg;
    localparam int unsigned WORD_W     = 32;
    localparam int unsigned PROD_W     = 64;
    localparam int unsigned FP_W       = 64;
    localparam int unsigned BYTE_MSB   = 7;
    localparam int unsigned HALF_MSB   = 15;
    localparam int unsigned FP_SGN_S   = 31;
    localparam int unsigned FP_SGN_D   = 63;
    // Multiply latency in execution states, inside the 2 to 5 window
    localparam int unsigned MUL_STATES = 3;
    localparam logic [2:0]  MUL_LAST   = 3'(MUL_STATES - 1);
    localparam logic [WORD_W-1:0] ONE_W     = 32'h0000_0001;
    localparam logic [WORD_W-1:0] ZERO_W    = 32'h0000_0000;
    localparam logic [PROD_W-1:0] MAC_RESET = 64'h0000_0000_0000_0000;
    localparam logic            FLAG_RESET = 1'b0;
    localparam logic            MODE_SINGLE = 1'b0;

    typedef enum logic [2:0] {
        WMX_OP_NONE  = 3'h0,
        WMX_OP_MULS  = 3'h1,
        WMX_OP_MULU  = 3'h2,
        WMX_OP_DEC   = 3'h3,
        WMX_OP_EXTSB = 3'h4,
        WMX_OP_EXTSW = 3'h5,
        WMX_OP_EXTUB = 3'h6,
        WMX_OP_EXTUW = 3'h7
    } wmx_op_t;

    typedef enum logic [1:0] {
        WMX_IDLE = 2'b00,
        WMX_BUSY = 2'b01,
        WMX_DONE = 2'b11
    } wmx_mul_state_t;
endpackage : wmx_pkg
`default_nettype wire

// file: hdl/wmx_extend.sv
// Sign and zero extension unit for bytes and words
`default_nettype none
module wmx_extend
    import wmx_pkg::*;
(
    input  wire logic [WORD_W-1:0] srcValue,
    input  wire logic              extWord,
    input  wire logic              extSigned,
    output logic      [WORD_W-1:0] extValue
);
    always_comb
    begin
        if (extWord)
        begin
            // Upper 16 bits: copy of bit 15 or zeros
            extValue = {{(WORD_W-HALF_MSB-1){extSigned & srcValue[HALF_MSB]}},
                        srcValue[HALF_MSB:0]};
        end
        else
        begin
            extValue = {{(WORD_W-BYTE_MSB-1){extSigned & srcValue[BYTE_MSB]}},
                        srcValue[BYTE_MSB:0]};
        end
    end
endmodule : wmx_extend
`default_nettype wire

// file: hdl/wmx_fp_abs.sv
// Floating-point absolute value: clears the sign bit only
`default_nettype none
module wmx_fp_abs
    import wmx_pkg::*;
(
    input  wire logic [FP_W-1:0] fpIn,
    input  wire logic            doubleModeSel,
    output logic      [FP_W-1:0] fpOut
);
    always_comb
    begin
        fpOut = fpIn;
        // Single uses low word; double clears the pair's top bit
        if (doubleModeSel == MODE_SINGLE)
            fpOut[FP_SGN_S] = 1'b0;
        else
            fpOut[FP_SGN_D] = 1'b0;
    end
endmodule : wmx_fp_abs
`default_nettype wire

// file: hdl/wmx_datapath.sv
// Wide multiply, decrement-and-test, extension and fp absolute-value datapath
// Function
// - Signed wide multiply: 32x32 two's complement, 64-bit into accumulator pair, 2-5 states.
// - Unsigned wide multiply: operands as magnitudes, 64-bit product into the pair.
// - Product upper half to mul_acc_high, lower half to mul_acc_low, both readable.
// - Decrement-and-test subtracts one from dest_reg, writes back, one state.
// - cmp_flag is one when decremented value is zero, else zero.
// - Byte sign extension copies bit 7 into bits 8 to 31.
// - Word sign extension copies bit 15 into bits 16 to 31.
// - Byte zero extension clears bits 8 to 31, keeps low byte.
// - Word zero extension clears bits 16 to 31, keeps low half.
// - fp absolute clears only the sign bit and writes back, one state.
// - fp absolute leaves cause and flag fields untouched, raises no exception.
// - Same sign clear in single and double; double uses even-register pair.
// - double_mode_sel zero selects single registers, one selects double pairs.
`default_nettype none
module wmx_datapath
    import wmx_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              opValid,
    input  wire wmx_op_t           opCode,
    input  wire logic [WORD_W-1:0] destRegIn,
    input  wire logic [WORD_W-1:0] srcRegIn,
    input  wire logic              fpAbsValid,
    input  wire logic              doubleModeSel,
    input  wire logic [FP_W-1:0]   fpRegIn,
    output logic                   opReady,
    output logic                   destWrite,
    output logic      [WORD_W-1:0] destRegOut,
    output logic                   fpWrite,
    output logic      [FP_W-1:0]   fpRegOut,
    output logic                   fpExcept,
    output logic                   fpStatWrite,
    output logic                   cmpFlag,
    output logic      [WORD_W-1:0] mulAccHigh,
    output logic      [WORD_W-1:0] mulAccLow,
    output logic                   mulBusy,
    output logic                   mulDone
);
    wmx_mul_state_t    mulState;
    logic [2:0]        mulCount;
    logic              mulSigned;
    logic [WORD_W-1:0] opA;
    logic [WORD_W-1:0] opB;
    logic [PROD_W-1:0] product;
    logic [WORD_W-1:0] extValue;
    logic [FP_W-1:0]   absValue;
    logic [WORD_W-1:0] decValue;
    logic              isMul;
    logic              isExt;
    logic              accept;

    assign isMul  = (opCode == WMX_OP_MULS) || (opCode == WMX_OP_MULU);
    assign isExt  = (opCode == WMX_OP_EXTSB) || (opCode == WMX_OP_EXTSW) ||
                    (opCode == WMX_OP_EXTUB) || (opCode == WMX_OP_EXTUW);
    // Stall new work while the multiplier holds its operands
    assign opReady = (mulState != WMX_BUSY);
    assign accept  = opValid && opReady;
    assign mulBusy = (mulState == WMX_BUSY);
    assign decValue = destRegIn - ONE_W;

    // Operands held so the register file may change under a multi-state multiply
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            opA       <= ZERO_W;
            opB       <= ZERO_W;
            mulSigned <= 1'b0;
        end
        else if (accept && isMul)
        begin
            opA       <= destRegIn;
            opB       <= srcRegIn;
            mulSigned <= (opCode == WMX_OP_MULS);
        end
    end

    always_comb
    begin
        if (mulSigned)
            product = PROD_W'($signed(opA) * $signed(opB));
        else
            product = opA * opB;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mulState <= WMX_IDLE;
            mulCount <= 3'h0;
        end
        else
        begin
            unique case (mulState)
                WMX_IDLE, WMX_DONE:
                begin
                    if (accept && isMul)
                    begin
                        mulState <= WMX_BUSY;
                        mulCount <= 3'h1;
                    end
                    else
                        mulState <= WMX_IDLE;
                end
                WMX_BUSY:
                begin
                    if (mulCount == MUL_LAST)
                        mulState <= WMX_DONE;
                    else
                        mulCount <= mulCount + 3'h1;
                end
                default:
                    mulState <= WMX_IDLE;
            endcase
        end
    end

    // Accumulator pair only changes once the product is final
    always_ff @(posedge clk)
    begin
        if (rst)
            {mulAccHigh, mulAccLow} <= MAC_RESET;
        else if (mulState == WMX_BUSY && mulCount == MUL_LAST)
        begin
            mulAccHigh <= product[PROD_W-1:WORD_W];
            mulAccLow  <= product[WORD_W-1:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            mulDone <= 1'b0;
        else
            mulDone <= (mulState == WMX_BUSY) && (mulCount == MUL_LAST);
    end

    wmx_extend u_extend (
        .srcValue  (srcRegIn),
        .extWord   ((opCode == WMX_OP_EXTSW) || (opCode == WMX_OP_EXTUW)),
        .extSigned ((opCode == WMX_OP_EXTSB) || (opCode == WMX_OP_EXTSW)),
        .extValue  (extValue)
    );

    wmx_fp_abs u_fp_abs (
        .fpIn          (fpRegIn),
        .doubleModeSel (doubleModeSel),
        .fpOut         (absValue)
    );

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            destWrite  <= 1'b0;
            destRegOut <= ZERO_W;
        end
        else
        begin
            destWrite <= accept && ((opCode == WMX_OP_DEC) || isExt);
            if (accept && opCode == WMX_OP_DEC)
                destRegOut <= decValue;
            else if (accept && isExt)
                destRegOut <= extValue;
        end
    end

    // Only decrement-and-test touches the flag
    always_ff @(posedge clk)
    begin
        if (rst)
            cmpFlag <= FLAG_RESET;
        else if (accept && opCode == WMX_OP_DEC)
            cmpFlag <= (decValue == ZERO_W);
    end

    // fp absolute runs beside the integer ops; it never stalls
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            fpWrite  <= 1'b0;
            fpRegOut <= 64'h0000_0000_0000_0000;
        end
        else
        begin
            fpWrite <= fpAbsValid;
            if (fpAbsValid)
                fpRegOut <= absValue;
        end
    end

    assign fpExcept    = 1'b0;
    assign fpStatWrite = 1'b0;
endmodule : wmx_datapath
`default_nettype wire

// file: tb/wmx_regfile_model.sv
// Register-file model that takes the datapath's write-backs
`default_nettype none
module wmx_regfile_model
    import wmx_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              destWrite,
    input  wire logic [WORD_W-1:0] destRegOut,
    input  wire logic              fpWrite,
    input  wire logic [FP_W-1:0]   fpRegOut,
    output logic      [WORD_W-1:0] gpr,
    output logic      [FP_W-1:0]   fpr
);
    timeunit 1ns;
    timeprecision 1ns;
    // Only write strobes update, so a missing pulse leaves a stale value
    always_ff @(posedge clk)
    begin
        if (destWrite)
            gpr <= destRegOut;
        if (fpWrite)
            fpr <= fpRegOut;
    end
endmodule : wmx_regfile_model
`default_nettype wire

// file: tb/wmx_datapath_assertions.sv
// Concurrent checks on the datapath's ports
`default_nettype none
module wmx_datapath_assertions
    import wmx_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              opValid,
    input wire wmx_op_t           opCode,
    input wire logic [WORD_W-1:0] destRegIn,
    input wire logic [WORD_W-1:0] srcRegIn,
    input wire logic              fpAbsValid,
    input wire logic              doubleModeSel,
    input wire logic [FP_W-1:0]   fpRegIn,
    input wire logic              opReady,
    input wire logic              destWrite,
    input wire logic [WORD_W-1:0] destRegOut,
    input wire logic              fpWrite,
    input wire logic [FP_W-1:0]   fpRegOut,
    input wire logic              fpExcept,
    input wire logic              fpStatWrite,
    input wire logic              cmpFlag,
    input wire logic [WORD_W-1:0] mulAccHigh,
    input wire logic [WORD_W-1:0] mulAccLow,
    input wire logic              mulBusy,
    input wire logic              mulDone
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire logic take = opValid && opReady;
    wire logic mul = opCode == WMX_OP_MULS || opCode == WMX_OP_MULU;
    function automatic logic [WORD_W-1:0] ext_of(input wmx_op_t o, input logic [WORD_W-1:0] v);
        case (o)
            WMX_OP_EXTSB: return {{24{v[7]}}, v[7:0]};
            WMX_OP_EXTSW: return {{16{v[15]}}, v[15:0]};
            WMX_OP_EXTUB: return {24'h00_0000, v[7:0]};
            default: return {16'h0000, v[15:0]};
        endcase
    endfunction : ext_of
    property p_muls;
        take && opCode == WMX_OP_MULS |-> ##3 $signed({mulAccHigh, mulAccLow}) ==
            $signed($past(destRegIn, 3)) * $signed($past(srcRegIn, 3));
    endproperty
    a_muls: assert property (p_muls) else $error("signed product wrong");
    property p_mulu;
        take && opCode == WMX_OP_MULU |-> ##3 {mulAccHigh, mulAccLow} ==
            $past(destRegIn, 3) * $past(srcRegIn, 3);
    endproperty
    a_mulu: assert property (p_mulu) else $error("unsigned product wrong");
    property p_mulbusy;
        take && mul |=> (mulBusy && !opReady) [*2] ##1 (mulDone && opReady);
    endproperty
    a_mulbusy: assert property (p_mulbusy) else $error("multiply handshake wrong");
    property p_dec;
        take && opCode == WMX_OP_DEC |=> destWrite && destRegOut == $past(destRegIn) - ONE_W;
    endproperty
    a_dec: assert property (p_dec) else $error("decrement result wrong");
    property p_decflag;
        take && opCode == WMX_OP_DEC |=> cmpFlag == ($past(destRegIn) == ONE_W);
    endproperty
    a_decflag: assert property (p_decflag) else $error("zero flag wrong");
    property p_ext;
        take && opCode >= WMX_OP_EXTSB |=>
            destWrite && destRegOut == ext_of($past(opCode), $past(srcRegIn));
    endproperty
    a_ext: assert property (p_ext) else $error("extension wrong");
    property p_fpabs;
        fpAbsValid |=> fpWrite && fpRegOut == ($past(fpRegIn) & ($past(doubleModeSel) ?
            64'h7FFF_FFFF_FFFF_FFFF : 64'hFFFF_FFFF_7FFF_FFFF));
    endproperty
    a_fpabs: assert property (p_fpabs) else $error("fp abs wrong");
    property p_noexc;
        !fpExcept && !fpStatWrite;
    endproperty
    a_noexc: assert property (p_noexc) else $error("fp status touched");
    property p_flagkeep;
        !(take && opCode == WMX_OP_DEC) |=> $stable(cmpFlag);
    endproperty
    a_flagkeep: assert property (p_flagkeep) else $error("flag changed");
    c_mul: cover property (take && mul ##3 mulDone);
    c_zero: cover property (take && opCode == WMX_OP_DEC ##1 cmpFlag);
    c_dbl: cover property (fpAbsValid && doubleModeSel);
endmodule : wmx_datapath_assertions
bind wmx_datapath wmx_datapath_assertions u_chk (.*);
`default_nettype wire

// file: tb/wmx_datapath_tb.sv
// Testbench: op sequences against worked-out results
`default_nettype none
module wmx_datapath_tb
    import wmx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, opValid = 1'b0, fpAbsValid = 1'b0, doubleModeSel = 1'b0;
    wmx_op_t opCode = WMX_OP_NONE;
    logic [WORD_W-1:0] destRegIn = '0, srcRegIn = '0, destRegOut, mulAccHigh, mulAccLow, gpr;
    logic [FP_W-1:0] fpRegIn = '0, fpRegOut, fpr;
    logic opReady, destWrite, fpWrite, fpExcept, fpStatWrite, cmpFlag, mulBusy, mulDone;
    int miscompares = 0, num_checks = 0;
    always #25 clk = ~clk;
    wmx_datapath dut (.*);
    wmx_regfile_model rf (.*);
    task automatic chk(input string what, input logic [FP_W-1:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out
    task automatic issue(input wmx_op_t op, input logic [WORD_W-1:0] d, s);
        @(posedge clk);
        opValid <= 1'b1;
        opCode <= op;
        destRegIn <= d;
        srcRegIn <= s;
        @(posedge clk);
        opValid <= 1'b0;
        @(negedge clk);
    endtask : issue
    task automatic int_op(input wmx_op_t op, input logic [WORD_W-1:0] d, s, exp);
        issue(op, d, s);
        chk("destWrite", 64'(destWrite), 64'h1);
        @(negedge clk);
        chk("gpr", 64'(gpr), 64'(exp));
    endtask : int_op
    task automatic mul_op(input wmx_op_t op, input logic [WORD_W-1:0] d, s,
                          input logic [PROD_W-1:0] exp);
        int n;
        issue(op, d, s);
        chk("opReady", 64'(opReady), 64'h0);
        chk("mulBusy", 64'(mulBusy), 64'h1);
        // Decrement offered while busy must be ignored
        @(posedge clk);
        opValid <= 1'b1;
        opCode <= WMX_OP_DEC;
        destRegIn <= 32'h0000_0005;
        @(posedge clk);
        opValid <= 1'b0;
        @(negedge clk);
        for (n = 0; n < 8 && mulDone !== 1'b1; n++)
            @(negedge clk);
        if (n == 8)
        begin
            miscompares++;
            close_out();
        end
        chk("mulAcc", {mulAccHigh, mulAccLow}, exp);
        chk("cmpFlag", 64'(cmpFlag), 64'h1);
    endtask : mul_op
    task automatic fp_op(input logic m, input logic [FP_W-1:0] v, exp);
        @(posedge clk);
        fpAbsValid <= 1'b1;
        doubleModeSel <= m;
        fpRegIn <= v;
        @(posedge clk);
        fpAbsValid <= 1'b0;
        @(negedge clk);
        chk("fpWrite", 64'(fpWrite), 64'h1);
        @(negedge clk);
        chk("fpr", fpr, exp);
    endtask : fp_op
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        int_op(WMX_OP_DEC, 32'h0000_0000, '0, 32'hFFFF_FFFF);
        chk("cmpFlag", 64'(cmpFlag), 64'h0);
        int_op(WMX_OP_DEC, 32'h0000_0001, '0, 32'h0000_0000);
        chk("cmpFlag", 64'(cmpFlag), 64'h1);
        int_op(WMX_OP_EXTSB, '0, 32'h1234_5680, 32'hFFFF_FF80);
        int_op(WMX_OP_EXTSB, '0, 32'hFFFF_FF7F, 32'h0000_007F);
        int_op(WMX_OP_EXTSW, '0, 32'h1234_8000, 32'hFFFF_8000);
        int_op(WMX_OP_EXTSW, '0, 32'hFFFF_7FFF, 32'h0000_7FFF);
        int_op(WMX_OP_EXTUB, '0, 32'hFFFF_FF80, 32'h0000_0080);
        int_op(WMX_OP_EXTUW, '0, 32'hFFFF_8000, 32'h0000_8000);
        mul_op(WMX_OP_MULS, 32'h0000_5555, 32'hFFFF_FFFE, 64'hFFFF_FFFF_FFFF_5556);
        mul_op(WMX_OP_MULU, 32'h0000_5555, 32'hFFFF_FFFE, 64'h0000_5554_FFFF_5556);
        fp_op(1'b0, 64'h8000_0001_FFFF_FFFF, 64'h8000_0001_7FFF_FFFF);
        fp_op(1'b1, 64'h8000_0001_FFFF_FFFF, 64'h0000_0001_FFFF_FFFF);
        chk("fpExcept", 64'(fpExcept | fpStatWrite), 64'h0);
        chk("cmpFlag", 64'(cmpFlag), 64'h1);
        close_out();
    end
endmodule : wmx_datapath_tb
`default_nettype wire
